// ### core/rst_pkg.sv
// constants, types and helpers for the reset source controller
// assumes a 32-bit apb slave decoding 16 byte-address bits
// How it works
// - every reset source (power-on, pin, software, watchdog, brown-out, mismatch) drives one master reset output.
// - a configuration mismatch reset sets the mismatch cause flag in bit 9.
// - the regulator standby bit 8 keeps the regulator on in sleep when one, standby tracking when zero.
// - a reset from the external clear pin sets the pin cause flag in bit 7.
// - an executed software reset sets the software cause flag in bit 6.
// - a watchdog expiry sets the watchdog time-out flag in bit 4.
// - waking from sleep sets bit 3 and waking from idle sets bit 2.
// - a brown-out sets the brown-out flag in bit 1, which also reads one after power-on.
// - a power-on reset sets the power-on flag in bit 0, so it reads one after power-up.
// - power-on and brown-out flags stay set until software writes zero, and must be cleared to see the next one.
// - unimplemented bits, bits 31-10 of the cause register among them, read zero and ignore writes.
// - writing one to trigger bit 0 requests a software reset, writing zero does nothing.
// - the trigger bit is write-only, resets to zero and is cleared by hardware after it is set.
// - trigger writes are ignored unless the unlock sequence was completed first.
// - cause, trigger and mask registers have clear, set and invert aliases at plus 0x4, 0x8 and 0xC; status has only clear, unlock none.
// - register values after reset depend on the configuration bits and on the kind of reset.
package rst_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] CAUSE_OFF = 16'hF600;
  localparam logic [15:0] TRIG_OFF = 16'hF610;
  localparam logic [15:0] UNLOCK_OFF = 16'hF620;
  localparam logic [15:0] IRQ_STAT_OFF = 16'hF630;
  localparam logic [15:0] IRQ_MASK_OFF = 16'hF640;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int POR_BIT = 0;
  localparam int BROWN_BIT = 1;
  localparam int IDLE_BIT = 2;
  localparam int SLEEP_BIT = 3;
  localparam int WDT_BIT = 4;
  localparam int SOFT_BIT = 6;
  localparam int EXT_BIT = 7;
  localparam int VREG_BIT = 8;
  localparam int MISMATCH_BIT = 9;
  localparam int TRIG_BIT = 0;
  localparam int CFG_VREG_BIT = 0;
  localparam logic [31:0] CAUSE_WMASK = 32'h0000_03DF;
  localparam logic [31:0] EVENT_MASK = 32'h0000_02DF;
  localparam logic [31:0] TRIG_WMASK = 32'h0000_0001;
  localparam logic [31:0] CAUSE_RST = 32'h0000_0003;
  // unlock keys, values arbitrary
  localparam logic [31:0] KEY1 = 32'h1234_ABCD;
  localparam logic [31:0] KEY2 = 32'hABCD_1234;
  // master reset stretch after the last request
  localparam logic [7:0] HOLD_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    ACC_PLAIN = 2'b00,
    ACC_CLR = 2'b01,
    ACC_SET = 2'b10,
    ACC_INV = 2'b11
  } acc_type;

  typedef enum logic [1:0] {
    LOCKED = 2'b00,
    KEY1_OK = 2'b01,
    UNLOCKED = 2'b10
  } unlock_type;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] apply_write(input logic [31:0] old, input logic [31:0] data,
                                              input acc_type kind, input logic [31:0] wmask);
    logic [31:0] val;
    val = old;
    case (kind)
      ACC_PLAIN: val = data;
      ACC_CLR: val = old & ~data;
      ACC_SET: val = old | data;
      ACC_INV: val = old ^ data;
      default: val = old;
    endcase
    return (old & ~wmask) | (val & wmask);
  endfunction

  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] base);
    return (addr[15:4] == base[15:4]) && (addr[1:0] == 2'b00);
  endfunction

endpackage

// ### core/reset_stretch.sv
// stretches a reset request into the master reset
// assumes req is synchronous to pclk
module reset_stretch
  import rst_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request in, stretched reset out
  input wire logic req,
  output logic rst_out
);

  logic [7:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= HOLD_CYCLES;
    end else if (req) begin
      cnt_r <= HOLD_CYCLES;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // high from power-on until the count runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_out <= 1'b1;
    end else begin
      rst_out <= req || (cnt_r != 8'h00);
    end
  end

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    $fell(req) |-> rst_out [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("master reset released too early");

endmodule

// ### core/reset_source_controller.sv
// reset source controller: cause flags, software trigger, master reset
// assumes an apb3 master on pclk and source inputs synchronous to pclk
//
// The APB interface to the registers was left to the implementer.
module reset_source_controller
  import rst_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset sources and wake events
  input wire logic ext_clear_pin_n,
  input wire logic watchdog_expire,
  input wire logic brownout_det,
  input wire logic config_mismatch,
  input wire logic sleep_wake,
  input wire logic idle_wake,
  input wire logic [7:0] device_configuration_bits,
  // outputs
  output logic master_system_reset,
  output logic regulator_standby_ctrl,
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] cause_r;
  logic [31:0] cause_nxt;
  logic [31:0] irq_stat_r;
  logic [31:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic [31:0] hw_set;
  logic [31:0] rd_val;
  logic [31:0] trig_val;
  logic pready_r;
  logic pslverr_r;
  logic trig_r;
  logic irq_r;
  logic cfg_done_r;
  logic setup;
  logic wr_done;
  logic mapped;
  logic rst_req;
  logic hit_cause;
  logic hit_trig;
  logic hit_unlock;
  logic hit_stat;
  logic hit_mask;
  acc_type kind;
  unlock_type unlock_r;

  // ****************************************
  // apb decode
  // ****************************************
  assign setup = psel && !penable && !pready_r;
  assign wr_done = psel && penable && pready_r && pwrite;
  assign kind = acc_type'(paddr[3:2]);
  assign hit_cause = reg_hit(paddr, CAUSE_OFF);
  assign hit_trig = reg_hit(paddr, TRIG_OFF);
  assign hit_unlock = reg_hit(paddr, UNLOCK_OFF);
  assign hit_stat = reg_hit(paddr, IRQ_STAT_OFF);
  assign hit_mask = reg_hit(paddr, IRQ_MASK_OFF);

  // aliases and write-only registers read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    if (hit_cause) begin
      rd_val = cause_r;
    end else if (hit_stat) begin
      rd_val = irq_stat_r;
    end else if (hit_mask) begin
      rd_val = irq_mask_r;
    end else if (!hit_trig && !hit_unlock) begin
      mapped = 1'b0;
    end
    if (kind != ACC_PLAIN) begin
      rd_val = 32'h0000_0000;
    end
  end

  // one wait-free access phase; pready comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // ****************************************
  // cause flags
  // ****************************************
  always_comb begin
    hw_set = 32'h0000_0000;
    hw_set[MISMATCH_BIT] = config_mismatch;
    hw_set[EXT_BIT] = !ext_clear_pin_n;
    hw_set[SOFT_BIT] = trig_r;
    hw_set[WDT_BIT] = watchdog_expire;
    hw_set[SLEEP_BIT] = sleep_wake;
    hw_set[IDLE_BIT] = idle_wake;
    hw_set[BROWN_BIT] = brownout_det;
  end

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    cause_nxt = cause_r;
    if (wr_done && hit_cause) begin
      cause_nxt = apply_write(cause_r, pwdata, kind, CAUSE_WMASK);
    end
    if (!cfg_done_r) begin
      cause_nxt[VREG_BIT] = device_configuration_bits[CFG_VREG_BIT];
    end
    cause_nxt = cause_nxt | hw_set;
  end

  // power-on leaves the power-on and brown-out flags set, the rest clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // strap caught once, on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done_r <= 1'b0;
    end else begin
      cfg_done_r <= 1'b1;
    end
  end

  // ****************************************
  // unlock sequence
  // ****************************************
  // any wrong word drops back to locked, so stray writes cannot arm it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= LOCKED;
    end else if (wr_done && hit_unlock && kind == ACC_PLAIN) begin
      case (unlock_r)
        LOCKED: begin
          unlock_r <= (pwdata == KEY1) ? KEY1_OK : LOCKED;
        end
        KEY1_OK: begin
          unlock_r <= (pwdata == KEY2) ? UNLOCKED : LOCKED;
        end
        UNLOCKED: begin
          unlock_r <= (pwdata == KEY1) ? KEY1_OK : LOCKED;
        end
        default: begin
          unlock_r <= LOCKED;
        end
      endcase
    end
  end

  // ****************************************
  // software reset trigger
  // ****************************************
  assign trig_val = apply_write(32'h0000_0000, pwdata, kind, TRIG_WMASK);

  // one-cycle pulse; never readable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= wr_done && hit_trig && (unlock_r == UNLOCKED) && trig_val[TRIG_BIT];
    end
  end

  // ****************************************
  // master reset
  // ****************************************
  assign rst_req = !ext_clear_pin_n || watchdog_expire || brownout_det || config_mismatch || trig_r;

  reset_stretch u_stretch (
    .pclk(pclk),
    .presetn(presetn),
    .req(rst_req),
    .rst_out(master_system_reset)
  );

  // ****************************************
  // interrupt
  // ****************************************
  // write one clears via plain or clear alias; set and invert are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 32'h0000_0000;
    end else if (wr_done && hit_stat && (kind == ACC_PLAIN || kind == ACC_CLR)) begin
      irq_stat_r <= (irq_stat_r & ~pwdata) | (hw_set & EVENT_MASK);
    end else begin
      irq_stat_r <= irq_stat_r | (hw_set & EVENT_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= 32'h0000_0000;
    end else if (wr_done && hit_mask) begin
      irq_mask_r <= apply_write(irq_mask_r, pwdata, kind, EVENT_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign regulator_standby_ctrl = cause_r[VREG_BIT];
  assign irq = irq_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_merge;
    brownout_det || config_mismatch || watchdog_expire || !ext_clear_pin_n |=> master_system_reset;
  endproperty
  a_merge: assert property (p_merge) else $error("source did not raise master reset");

  property p_mismatch;
    config_mismatch |=> cause_r[MISMATCH_BIT];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch flag not set");

  property p_vreg;
    wr_done && hit_cause && kind == ACC_PLAIN && cfg_done_r |=>
      regulator_standby_ctrl == $past(pwdata[VREG_BIT]);
  endproperty
  a_vreg: assert property (p_vreg) else $error("standby control not written");

  property p_ext;
    !ext_clear_pin_n |=> cause_r[EXT_BIT];
  endproperty
  a_ext: assert property (p_ext) else $error("pin flag not set");

  property p_soft;
    trig_r |=> cause_r[SOFT_BIT] && master_system_reset;
  endproperty
  a_soft: assert property (p_soft) else $error("software reset not recorded");

  property p_wdt;
    watchdog_expire |=> cause_r[WDT_BIT];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog flag not set");

  property p_wake;
    sleep_wake || idle_wake |=>
      (cause_r[SLEEP_BIT] || !$past(sleep_wake)) && (cause_r[IDLE_BIT] || !$past(idle_wake));
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag not set");

  property p_brown;
    brownout_det |=> cause_r[BROWN_BIT];
  endproperty
  a_brown: assert property (p_brown) else $error("brown-out flag not set");

  property p_sticky;
    !(wr_done && hit_cause) |=> (cause_r[1:0] & $past(cause_r[1:0])) == $past(cause_r[1:0]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("power flag lost without a write");

  property p_upper;
    pready_r |-> prdata_r[31:10] == 22'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("unimplemented bits read nonzero");

  property p_trig_cause;
    trig_r |-> $past(wr_done && hit_trig && unlock_r == UNLOCKED);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("trigger without unlocked write");

  property p_trig_clear;
    trig_r |=> !trig_r;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger not self-cleared");

  property p_alias_set;
    wr_done && hit_mask && kind == ACC_SET |=>
      (irq_mask_r & $past(pwdata) & EVENT_MASK) == ($past(pwdata) & EVENT_MASK);
  endproperty
  a_alias_set: assert property (p_alias_set) else $error("set alias did not set bits");

  property p_locked_trig;
    wr_done && hit_trig && unlock_r != UNLOCKED |=> !trig_r;
  endproperty
  a_locked_trig: assert property (p_locked_trig) else $error("locked trigger write took effect");

  property p_zero_trig;
    wr_done && hit_trig && !trig_val[TRIG_BIT] |=> !trig_r;
  endproperty
  a_zero_trig: assert property (p_zero_trig) else $error("zero trigger write took effect");

  property p_trig_read;
    pready_r && hit_trig |-> prdata_r == 32'h0000_0000;
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger register read nonzero");

  property p_unimpl;
    (cause_r & ~CAUSE_WMASK) == 32'h0000_0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented cause bit set");

  property p_strap;
    !cfg_done_r |=> regulator_standby_ctrl == $past(device_configuration_bits[CFG_VREG_BIT]);
  endproperty
  a_strap: assert property (p_strap) else $error("standby strap not loaded");

  property p_irq;
    (irq_stat_r & irq_mask_r) != 32'h0000_0000 |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event did not raise irq");

endmodule

// ### tb/tb_top.sv
// self-checking bench for the reset source controller
// assumes rst_pkg and the core files are compiled before it
module tb_top
  import rst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ext_clear_pin_n, watchdog_expire, brownout_det, config_mismatch, sleep_wake, idle_wake;
  logic [7:0] device_configuration_bits;
  logic master_system_reset, regulator_standby_ctrl, irq, vreg;
  logic [32:0] notes[$];
  int err_count, checked, n, seed;
  logic [31:0] d;
  int bitpos[6] = '{WDT_BIT, BROWN_BIT, MISMATCH_BIT, EXT_BIT, SLEEP_BIT, IDLE_BIT};

  reset_source_controller reset_source_controller_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clear_pin_n(ext_clear_pin_n), .watchdog_expire(watchdog_expire),
    .brownout_det(brownout_det), .config_mismatch(config_mismatch), .sleep_wake(sleep_wake),
    .idle_wake(idle_wake), .device_configuration_bits(device_configuration_bits),
    .master_system_reset(master_system_reset), .regulator_standby_ctrl(regulator_standby_ctrl),
    .irq(irq)
  );

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // answers are matched against the oldest note, in bus order
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (notes.size() == 0) chk("unexpected answer", 33'h0, 33'h1);
      else chk("apb answer", {pslverr, prdata}, notes.pop_front());
    end
  end

  // ****************************************
  // bus and stimulus tasks
  // ****************************************
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd, input logic [32:0] exp);
    int k;
    notes.push_back(exp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, {1'b0, exp});
  endtask

  // waits for the master reset to drop, counting edges
  task automatic wait_low(output int c);
    c = 0;
    while (master_system_reset !== 1'b0 && c < 60) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 60) begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic src(input int k, input logic v);
    case (k)
      0: watchdog_expire <= v;
      1: brownout_det <= v;
      2: config_mismatch <= v;
      3: ext_clear_pin_n <= ~v;
      4: sleep_wake <= v;
      default: idle_wake <= v;
    endcase
  endtask

  // one-cycle event; the first four kinds are reset sources
  task automatic fire(input int k, input logic irq_on);
    int c;
    logic [31:0] b;
    b = 32'h1 << bitpos[k];
    src(k, 1'b1);
    @(posedge pclk);
    src(k, 1'b0);
    @(posedge pclk);
    chk("reset on event", 33'(master_system_reset), 33'(k < 4));
    wait_low(c);
    if (k < 4) chk("reset stretch", 33'(c), 33'(HOLD_CYCLES) + 33'd1);
    repeat (3) @(posedge pclk);
    chk("irq raised", 33'(irq), 33'(irq_on));
    rd(CAUSE_OFF, b | (32'(vreg) << 8));
    wr(CAUSE_OFF + 16'h4, b);
    wr(IRQ_STAT_OFF, EVENT_MASK);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 33'(irq), 33'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    #(20 * 100000);
    err_count++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {watchdog_expire, brownout_det, config_mismatch, sleep_wake, idle_wake} = '0;
    ext_clear_pin_n = 1'b1;
    seed = $urandom(49);
    device_configuration_bits = 8'($urandom());
    vreg = device_configuration_bits[0];
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset held", 33'(master_system_reset), 33'h1);
    wait_low(n);
    rd(CAUSE_OFF, CAUSE_RST | (32'(vreg) << 8));
    rd(TRIG_OFF, 32'h0);
    chk("standby out", 33'(regulator_standby_ctrl), 33'(vreg));
    $display("test done: reset values");

    wr(CAUSE_OFF + 16'h4, 32'hFFFF_FEFF);
    rd(CAUSE_OFF, 32'(vreg) << 8);
    wr(CAUSE_OFF + 16'hC, 32'h0000_0100);
    vreg = ~vreg;
    rd(CAUSE_OFF + 16'h8, 32'h0);
    chk("standby invert", 33'(regulator_standby_ctrl), 33'(vreg));
    wr(CAUSE_OFF + 16'h8, 32'hFFFF_FC20);
    rd(CAUSE_OFF, 32'(vreg) << 8);
    repeat (4) begin
      d = $urandom();
      wr(CAUSE_OFF, d);
      vreg = d[8];
      rd(CAUSE_OFF, d & CAUSE_WMASK);
      chk("standby write", 33'(regulator_standby_ctrl), 33'(vreg));
    end
    wr(CAUSE_OFF + 16'h4, EVENT_MASK);
    $display("test done: aliases and unimplemented bits");

    wr(IRQ_STAT_OFF, EVENT_MASK);
    wr(IRQ_MASK_OFF, EVENT_MASK);
    for (int k = 0; k < 6; k++) fire(k, 1'b1);
    wr(IRQ_MASK_OFF, 32'h0);
    fire(1, 1'b0);
    $display("test done: reset sources and interrupt");

    // a locked trigger write must not reset
    wr(TRIG_OFF, 32'h1);
    repeat (4) @(posedge pclk);
    chk("locked trigger", 33'(master_system_reset), 33'h0);
    wr(UNLOCK_OFF, KEY1);
    wr(UNLOCK_OFF, KEY2);
    wr(TRIG_OFF, 32'h0);
    repeat (4) @(posedge pclk);
    chk("zero trigger", 33'(master_system_reset), 33'h0);
    rd(CAUSE_OFF, 32'(vreg) << 8);
    wr(TRIG_OFF + 16'h8, 32'h1);
    n = 0;
    while (master_system_reset !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk("soft reset", 33'(master_system_reset), 33'h1);
    wait_low(n);
    rd(CAUSE_OFF, (32'h1 << SOFT_BIT) | (32'(vreg) << 8));
    rd(TRIG_OFF, 32'h0);
    $display("test done: software reset");

    apb(1'b0, 16'hF650, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 16'hF602, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 16'hF6F0, 32'hFFFF_FFFF, {1'b1, 32'h0});
    rd(CAUSE_OFF, (32'h1 << SOFT_BIT) | (32'(vreg) << 8));
    $display("test done: unmapped addresses");

    // second power-on in mid-run, strap redrawn
    d = $urandom();
    device_configuration_bits <= d[7:0];
    vreg = d[0];
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset again", 33'(master_system_reset), 33'h1);
    wait_low(n);
    chk("reset length", 33'(n), 33'(HOLD_CYCLES) + 33'd1);
    rd(CAUSE_OFF, CAUSE_RST | (32'(vreg) << 8));
    chk("standby strap", 33'(regulator_standby_ctrl), 33'(vreg));
    $display("test done: second reset");
    end_of_test();
  end
endmodule
